// file: hw/adcsr_pkg.sv
// Shared constants and carrier types for the converter readout chain
package adcsr_pkg;
	localparam int RESULT_W = 16;
	// Conversion time window in ns
	localparam int T_CONV_MIN_NS = 500;
	localparam int T_CONV_MAX_NS = 1600;
	localparam int CLK_NS = 10;
	localparam int CONV_MIN_CYC = (T_CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_MAX_CYC = T_CONV_MAX_NS / CLK_NS;
	localparam int CONV_CYC = CONV_MAX_CYC;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [4:0] TAIL_EDGE_SEL = 5'h10;
	localparam logic [4:0] TAIL_EDGE_BUSY = 5'h11;

	typedef enum logic [2:0] {
		ADCSR_IDLE = 3'h0,
		ADCSR_CONV = 3'h1,
		ADCSR_SHIFT = 3'h3,
		ADCSR_DONE = 3'h2
	} adcsr_state_t;

	// Serial output pin: data level and drive enable
	typedef struct packed {
		logic o;
		logic oe;
	} adcsr_pin_t;

	// Mode captured at start; in select mode busy_en is set at conversion end unless select and start are both still high
	typedef struct packed {
		logic chain;
		logic busy_en;
	} adcsr_mode_t;
endpackage

// file: hw/adcsr_readout.sv
// Conversion-start and serial readback logic of a 16-bit sampling converter
`timescale 1ns/1ns
`default_nettype none
module adcsr_readout #(
	parameter int CONV_CYCLES = adcsr_pkg::CONV_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic convert_start_i,
	input wire logic serial_in_select_i,
	input wire logic sclk_i,
	input wire logic [15:0] result_i,
	output logic serial_result_out_o,
	output logic serial_result_out_oe_o,
	output logic conv_done_o
);
	// Two-stage synchronisers; stage one read only by stage two
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic cnv_d;
	logic sdi_d;
	logic sck_d;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			cnv_d <= 1'b0;
			sdi_d <= 1'b0;
			sck_d <= 1'b0;
		end else begin
			sync1 <= {convert_start_i, serial_in_select_i, sclk_i};
			sync2 <= sync1;
			cnv_d <= sync2[2];
			sdi_d <= sync2[1];
			sck_d <= sync2[0];
		end
	end
	logic convert_start;
	logic serial_in_select;
	logic sck;
	logic cnv_rise;
	logic sdi_rise;
	logic sck_fall;
	assign convert_start = sync2[2];
	assign serial_in_select = sync2[1];
	assign sck = sync2[0];
	assign cnv_rise = convert_start & ~cnv_d;
	assign sdi_rise = serial_in_select & ~sdi_d;
	assign sck_fall = ~sck & sck_d;

	adcsr_pkg::adcsr_state_t state;
	adcsr_pkg::adcsr_state_t next_state;
	adcsr_pkg::adcsr_mode_t mode;
	adcsr_pkg::adcsr_mode_t next_mode;
	adcsr_pkg::adcsr_pin_t pin;
	adcsr_pkg::adcsr_pin_t next_pin;
	logic [15:0] conv_cnt;
	logic [15:0] next_conv_cnt;
	logic [15:0] shreg;
	logic [15:0] next_shreg;
	logic [4:0] edges;
	logic [4:0] next_edges;
	logic done;
	logic next_done;

	always_comb begin
		next_state = state;
		next_mode = mode;
		next_pin = pin;
		next_conv_cnt = conv_cnt;
		next_shreg = shreg;
		next_edges = edges;
		next_done = 1'b0;
		case (state)
			adcsr_pkg::ADCSR_IDLE: begin
				if (!serial_in_select && !convert_start) begin
					next_pin = '{o: 1'b0, oe: 1'b1};
				end
				if (cnv_rise) begin
					// Serial input decides select or chain mode
					next_mode.chain = ~sdi_d;
					next_mode.busy_en = ~sdi_d & sck_d;
					next_conv_cnt = 16'(CONV_CYCLES - 1);
					next_edges = 5'h00;
					next_state = adcsr_pkg::ADCSR_CONV;
					if (sdi_d) begin
						next_pin = '{o: 1'b0, oe: 1'b0};
					end
				end
			end
			adcsr_pkg::ADCSR_CONV: begin
				// Convert start ignored until the count runs out
				if (conv_cnt != 16'h0000) begin
					next_conv_cnt = conv_cnt - 16'h0001;
				end else begin
					next_shreg = result_i;
					next_done = 1'b1;
					next_state = adcsr_pkg::ADCSR_SHIFT;
					if (mode.chain) begin
						// Busy chain: high flag bit before data
						next_pin = '{o: mode.busy_en ? 1'b1 : result_i[15], oe: 1'b1};
						next_mode.busy_en = mode.busy_en;
					end else if (!serial_in_select || !convert_start) begin
						next_mode.busy_en = 1'b1;
						next_pin = '{o: 1'b0, oe: 1'b1};
					end else begin
						next_pin = '{o: 1'b0, oe: 1'b0};
					end
				end
			end
			adcsr_pkg::ADCSR_SHIFT: begin
				if (mode.chain) begin
					if (sck_fall) begin
						// Output changes only on falls, so held over both edges
						next_shreg = {shreg[14:0], serial_in_select};
						next_pin.o = mode.busy_en ? shreg[15] : shreg[14];
						next_edges = edges + 5'h01;
					end
					if (cnv_rise) begin
						next_state = adcsr_pkg::ADCSR_IDLE;
					end
				end else begin
					if (!serial_in_select) begin
						if (!pin.oe) begin
							// Select low without busy: MSB presented at once
							next_pin = '{o: shreg[15], oe: 1'b1};
						end else if (sck_fall) begin
							next_pin.o = mode.busy_en ? shreg[15] : shreg[14];
							next_shreg = {shreg[14:0], 1'b0};
							next_edges = edges + 5'h01;
						end
					end
					if (sdi_rise || (sck_fall && next_edges == (mode.busy_en ?
						adcsr_pkg::TAIL_EDGE_BUSY : adcsr_pkg::TAIL_EDGE_SEL))) begin
						next_pin = '{o: 1'b0, oe: 1'b0};
						next_state = adcsr_pkg::ADCSR_DONE;
					end
				end
			end
			adcsr_pkg::ADCSR_DONE: begin
				next_state = adcsr_pkg::ADCSR_IDLE;
			end
			default: begin
				next_state = adcsr_pkg::ADCSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= adcsr_pkg::ADCSR_IDLE;
			mode <= '0;
			pin <= '0;
			conv_cnt <= 16'h0000;
			shreg <= adcsr_pkg::RESULT_RST;
			edges <= 5'h00;
			done <= 1'b0;
		end else begin
			state <= next_state;
			mode <= next_mode;
			pin <= next_pin;
			conv_cnt <= next_conv_cnt;
			shreg <= next_shreg;
			edges <= next_edges;
			done <= next_done;
		end
	end

	assign serial_result_out_o = pin.o;
	assign serial_result_out_oe_o = pin.oe;
	assign conv_done_o = done;

	property p_start_float;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_IDLE && cnv_rise && sdi_d) |=> !serial_result_out_oe_o;
	endproperty
	a_start_float: assert property (p_start_float) else $error("output not floated at start");

	property p_drive_low;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_IDLE && !serial_in_select && !convert_start && !cnv_rise)
			|=> serial_result_out_oe_o && !serial_result_out_o;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("output not driven low");

	property p_conv_len;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_IDLE && cnv_rise) |=> (state == adcsr_pkg::ADCSR_CONV)
			##CONV_CYCLES conv_done_o;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	property p_conv_bounds;
		@(posedge clk_i) CONV_CYCLES >= adcsr_pkg::CONV_MIN_CYC && CONV_CYCLES <= adcsr_pkg::CONV_MAX_CYC;
	endproperty
	a_conv_bounds: assert property (p_conv_bounds) else $error("conversion length out of bounds");

	property p_busy_low;
		@(posedge clk_i) disable iff (!rst_b_i)
		(conv_done_o && !mode.chain && mode.busy_en) |-> serial_result_out_oe_o && !serial_result_out_o;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("busy low not driven");

	property p_chain_busy_high;
		@(posedge clk_i) disable iff (!rst_b_i)
		(conv_done_o && mode.chain && mode.busy_en) |-> serial_result_out_o && serial_result_out_oe_o;
	endproperty
	a_chain_busy_high: assert property (p_chain_busy_high) else $error("chain busy not high");

	property p_chain_msb;
		@(posedge clk_i) disable iff (!rst_b_i)
		(conv_done_o && mode.chain && !mode.busy_en) |-> serial_result_out_o == shreg[15];
	endproperty
	a_chain_msb: assert property (p_chain_msb) else $error("chain MSB not presented");

	property p_chain_shift;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_SHIFT && mode.chain && sck_fall && !cnv_rise)
			|=> shreg == {$past(shreg[14:0]), $past(serial_in_select)};
	endproperty
	a_chain_shift: assert property (p_chain_shift) else $error("chain shift wrong");

	property p_stable;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_SHIFT && pin.oe && !sck_fall && !sdi_rise)
			|=> $stable(serial_result_out_o);
	endproperty
	a_stable: assert property (p_stable) else $error("output changed off falling edge");

	property p_float_sdi;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_SHIFT && !mode.chain && sdi_rise) |=> !serial_result_out_oe_o;
	endproperty
	a_float_sdi: assert property (p_float_sdi) else $error("no float on select high");

	property p_mode_pick;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_IDLE && cnv_rise) |=> mode.chain == !$past(sdi_d)
			&& (mode.busy_en == ($past(!sdi_d) && $past(sck_d)));
	endproperty
	a_mode_pick: assert property (p_mode_pick) else $error("mode chosen wrongly");

	property p_conv_hold;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_CONV && conv_cnt != 16'h0000) |=> (state == adcsr_pkg::ADCSR_CONV);
	endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("conversion left early");

	property p_conv_float;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_CONV && !mode.chain) |-> !serial_result_out_oe_o;
	endproperty
	a_conv_float: assert property (p_conv_float) else $error("output driven in conversion");

	property p_done_shift;
		@(posedge clk_i) disable iff (!rst_b_i)
		conv_done_o |-> (state == adcsr_pkg::ADCSR_SHIFT) ##1 !conv_done_o;
	endproperty
	a_done_shift: assert property (p_done_shift) else $error("no readback after completion");

	// Select mode without busy: nothing driven until select falls
	property p_nobusy_msb;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_SHIFT && !mode.chain && !serial_in_select && !pin.oe)
			|=> serial_result_out_oe_o && serial_result_out_o == $past(shreg[15]);
	endproperty
	a_nobusy_msb: assert property (p_nobusy_msb) else $error("MSB not presented");

	property p_chain_out;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_SHIFT && mode.chain && sck_fall)
			|=> serial_result_out_o == (mode.busy_en ? $past(shreg[15]) : $past(shreg[14]));
	endproperty
	a_chain_out: assert property (p_chain_out) else $error("chain output bit wrong");

	// Last counted fall floats the pin; busy mode counts the flag bit too
	property p_tail_float;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state == adcsr_pkg::ADCSR_SHIFT && !mode.chain && !serial_in_select && pin.oe && sck_fall
			&& (edges + 5'h01) == (mode.busy_en ? adcsr_pkg::TAIL_EDGE_BUSY
			: adcsr_pkg::TAIL_EDGE_SEL)) |=> !serial_result_out_oe_o;
	endproperty
	a_tail_float: assert property (p_tail_float) else $error("no float at last fall");
endmodule
`default_nettype wire

// file: verification/adcsr_host.sv
// Host model: drives start, select and serial clock, reads the pulled-up line
`timescale 1ns/1ns
`default_nettype none
module adcsr_host (
	input wire logic clk_i,
	input wire logic dout_i,
	input wire logic doe_i,
	input wire logic done_i,
	output logic cnv_o,
	output logic sel_o,
	output logic sclk_o,
	output logic line_o
);
	// Pull-up, so a floated line reads high
	assign line_o = doe_i ? dout_i : 1'b1;
	task automatic drive(input logic convert_start, input logic sel, input logic sck);
		cnv_o = convert_start;
		sel_o = sel;
		sclk_o = sck;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Levels of sel and sck at the rise pick the mode; keep holds select high (no busy)
	task automatic start(input logic sel, input logic sck, input logic keep, output int cyc,
		output logic oe_mid);
		sel_o = sel;
		sclk_o = sck;
		tick(2);
		cnv_o = 1'b1;
		tick(3);
		sel_o = sel & keep;
		cyc = 3;
		oe_mid = 1'bx;
		while (done_i !== 1'b1 && cyc < 400) begin
			if (cyc == 20)
				oe_mid = doe_i;
			tick(1);
			cyc++;
		end
	endtask
	// Reads before each fall, at the end of the high phase, so either edge would do
	task automatic shift(input int n, input logic [31:0] din, output logic [31:0] q);
		q = '0;
		for (int i = 0; i < n; i++) begin
			sclk_o = 1'b1;
			sel_o = din[n-1-i];
			tick(4);
			q = {q[30:0], line_o};
			sclk_o = 1'b0;
			tick(4);
		end
	endtask
endmodule
`default_nettype wire

// file: verification/tb_adc_serial_readout_chain.sv
// Self-checking bench for the converter readout chain
`timescale 1ns/1ns
`default_nettype none
module tb_adc_serial_readout_chain;
	localparam int CONV = 50;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] res = 16'ha5c3;
	logic dout, doe, done, convert_start, sel, sclk, line;
	int n_errors = 0;
	int n_checks = 0;
	int cyc;
	logic oe_mid;
	logic [31:0] q;
	always #5 clk = ~clk;
	adcsr_readout #(.CONV_CYCLES(CONV)) i_dut (.clk_i(clk), .rst_b_i(rst_b),
		.convert_start_i(convert_start), .serial_in_select_i(sel), .sclk_i(sclk), .result_i(res),
		.serial_result_out_o(dout), .serial_result_out_oe_o(doe), .conv_done_o(done));
	adcsr_host i_host (.clk_i(clk), .dout_i(dout), .doe_i(doe), .done_i(done),
		.cnv_o(convert_start), .sel_o(sel), .sclk_o(sclk), .line_o(line));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Fresh reset per test, since chain mode only leaves on a new rise
	task automatic do_reset();
		rst_b = 1'b0;
		i_host.drive(1'b0, 1'b0, 1'b0);
		i_host.tick(12);
		rst_b = 1'b1;
		i_host.tick(4);
	endtask
	task automatic t_select_busy();
		do_reset();
		check("idle_oe", doe, 1);
		check("idle_out", dout, 0);
		i_host.start(1'b1, 1'b0, 1'b0, cyc, oe_mid);
		check("conv_float", oe_mid, 0);
		check("conv_time", (cyc >= CONV) && (cyc <= CONV + 6), 1);
		check("busy_low", {doe, line}, 2'b10);
		i_host.shift(17, 0, q);
		check("sel_data", q[16:0], {1'b0, res});
		check("tail_float", doe, 0);
		$display("test select_busy done");
	endtask
	task automatic t_select_abort();
		do_reset();
		i_host.start(1'b1, 1'b0, 1'b0, cyc, oe_mid);
		i_host.shift(4, 0, q);
		i_host.drive(1'b1, 1'b1, 1'b0);
		i_host.tick(5);
		check("abort_float", doe, 0);
		check("abort_bits", q[3:0], {1'b0, res[15:13]});
		$display("test select_abort done");
	endtask
	task automatic t_select_nobusy();
		do_reset();
		res = 16'h4d2b;
		i_host.start(1'b1, 1'b0, 1'b1, cyc, oe_mid);
		check("nb_float", doe, 0);
		i_host.drive(1'b1, 1'b0, 1'b0);
		i_host.tick(4);
		check("nb_msb", {doe, line}, {1'b1, res[15]});
		i_host.shift(16, 0, q);
		check("nb_data", q[15:0], res);
		check("nb_tail", doe, 0);
		$display("test select_nobusy done");
	endtask
	task automatic t_chain_busy();
		do_reset();
		res = 16'h5a3c;
		i_host.start(1'b0, 1'b1, 1'b0, cyc, oe_mid);
		check("chain_flag", line, 1);
		i_host.shift(17, 0, q);
		check("chainb_data", q[16:0], {1'b1, res});
		$display("test chain_busy done");
	endtask
	task automatic t_chain();
		do_reset();
		res = 16'h8e71;
		i_host.start(1'b0, 1'b0, 1'b0, cyc, oe_mid);
		check("chain_msb", line, res[15]);
		// Upstream word goes in first and leaves after our own
		i_host.shift(32, {16'h3c96, 16'h0000}, q);
		check("chain_data", q, {res, 16'h3c96});
		$display("test chain done");
	endtask
	initial begin
		t_select_busy();
		t_select_abort();
		t_select_nobusy();
		t_chain_busy();
		t_chain();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule
`default_nettype wire
